// file: design/pcm_defines.svh
// offsets, field positions, reset values and timing counts for the charging mode block
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH
`define PCM_NPORT          4
`define PCM_ADDR_CHG_EN    8'h00
`define PCM_ADDR_CTRL      8'h04
`define PCM_ADDR_CTRL2     8'h08
`define PCM_ADDR_STRAPS    8'h0c
`define PCM_ADDR_STATUS    8'h10
`define PCM_CTRL_DIVSEL    4
`define PCM_CTRL_AUTODIS   1
`define PCM_CTRL2_FULL     0
`define PCM_CTRL2_HSET_N   1
`define PCM_RST_CHG_EN     4'h0
`define PCM_RST_CTRL       8'h02
`define PCM_RST_CTRL2      8'h00
`define PCM_OFF_TIME_NS    1000
`define PCM_CLK_NS         5
`define PCM_OFF_CYC        ((`PCM_OFF_TIME_NS + `PCM_CLK_NS - 1) / `PCM_CLK_NS)
`endif

// file: design/pcm_pkg.sv
// types for the charging mode block
package pcm_pkg;
    typedef enum logic [2:0] {
        PCM_NONE = 3'b000,
        PCM_CDP  = 3'b001,
        PCM_HIGH = 3'b010,
        PCM_MID  = 3'b011,
        PCM_LOW  = 3'b100,
        PCM_HSET = 3'b101,
        PCM_DCP  = 3'b110
    } pcm_mode_t;
    typedef struct packed {
        logic [3:0] charge_enable_straps;
        logic       auto_cycle_pin_n;
        logic       full_cycle_pin;
        logic       power_switching_disable_pin;
        logic       ganged_pin;
        logic       serial_slave_select_pin;
        logic       power_enable_polarity_pin;
    } pcm_straps_t;
    typedef struct packed {
        logic       vbus_valid;
        logic       configured;
        logic       host_port_power;
    } pcm_upstream_t;
endpackage

// file: design/pcm_ctrl.sv
// per-port charging mode controller with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pcm_defines.svh"
module pcm_ctrl (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire pcm_pkg::pcm_straps_t   straps,
    input  wire pcm_pkg::pcm_upstream_t upstream,
    input  wire logic                   memory_present,
    input  wire logic [3:0]             dp_pullup_detect,
    input  wire logic [3:0]             line_voltage_detect,
    output logic [3:0]                  port_power_enable,
    output logic                        per_port_switching,
    output logic [11:0]                 port_mode,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    import pcm_pkg::*;

    localparam int OFF_CYC = `PCM_OFF_CYC;

    pcm_straps_t   strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
    pcm_upstream_t up_s1_q, up_s2_q, up_s3_q, up_q;
    logic [3:0]    pu_s1_q, pu_s2_q, pu_s3_q, pu_q;
    logic [3:0]    lv_s1_q, lv_s2_q, lv_s3_q, lv_q;
    logic          mem_s1_q, mem_s2_q, mem_s3_q, mem_q;
    logic          captured_q;
    logic [3:0]    port_charge_enable_q;
    logic [7:0]    ctrl_q;
    logic [7:0]    ctrl2_q;
    logic [3:0]    chg_en;
    logic          auto_cycle_mode, full_cycle, hset_en, div_high, connected;
    pcm_mode_t     top_div;
    logic          aw_q, w_q;
    logic [7:0]    awaddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;

    // three-stage input synchronisers; change taken when stages two and three agree
    always_ff @(posedge aclk) begin
        strap_s1_q <= straps;
        strap_s2_q <= strap_s1_q;
        strap_s3_q <= strap_s2_q;
        up_s1_q    <= upstream;
        up_s2_q    <= up_s1_q;
        up_s3_q    <= up_s2_q;
        pu_s1_q    <= dp_pullup_detect;
        pu_s2_q    <= pu_s1_q;
        pu_s3_q    <= pu_s2_q;
        lv_s1_q    <= line_voltage_detect;
        lv_s2_q    <= lv_s1_q;
        lv_s3_q    <= lv_s2_q;
        mem_s1_q   <= memory_present;
        mem_s2_q   <= mem_s1_q;
        mem_s3_q   <= mem_s2_q;
    end

    // filtered views of the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_q  <= '0;
            pu_q  <= 4'h0;
            lv_q  <= 4'h0;
            mem_q <= 1'b0;
        end else begin
            if (up_s2_q == up_s3_q) up_q <= up_s3_q;
            pu_q <= (pu_s2_q & pu_s3_q) | (pu_q & (pu_s2_q | pu_s3_q));
            lv_q <= (lv_s2_q & lv_s3_q) | (lv_q & (lv_s2_q | lv_s3_q));
            if (mem_s2_q == mem_s3_q) mem_q <= mem_s3_q;
        end
    end

    // strap capture on the first cycle after reset release in which stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            captured_q <= 1'b0;
            strap_q    <= '0;
        end else if (!captured_q && strap_s2_q == strap_s3_q) begin
            captured_q <= 1'b1;
            strap_q    <= strap_s3_q;
        end
    end

    // effective configuration: enable, cycling from registers with memory, straps without; full cycle from either; connected from up_q; rest from registers
    always_comb begin
        chg_en          = mem_q ? port_charge_enable_q
                                : strap_q.charge_enable_straps;
        auto_cycle_mode = mem_q ? !ctrl_q[`PCM_CTRL_AUTODIS]
                                : !strap_q.auto_cycle_pin_n;
        full_cycle      = ctrl2_q[`PCM_CTRL2_FULL] | strap_q.full_cycle_pin;
        hset_en         = !ctrl2_q[`PCM_CTRL2_HSET_N];
        div_high        = !ctrl_q[`PCM_CTRL_DIVSEL];
        top_div         = (full_cycle || div_high) ? PCM_HIGH : PCM_MID;
        connected       = up_q.vbus_valid;
    end

    // per-port mode machines
    genvar gi;
    generate
        for (gi = 0; gi < `PCM_NPORT; gi++) begin : g_port
            pcm_mode_t mode_q;
            pcm_mode_t after_q;
            logic [7:0] off_q;
            logic       ev;
            assign ev = pu_q[gi];
            always_ff @(posedge aclk) begin
                if (!aresetn || !captured_q) begin
                    mode_q                <= PCM_NONE;
                    after_q               <= PCM_NONE;
                    off_q                 <= 8'h00;
                    port_power_enable[gi] <= 1'b0;
                end else if (!chg_en[gi]) begin
                    mode_q                <= PCM_NONE;
                    off_q                 <= 8'h00;
                    port_power_enable[gi] <= up_q.host_port_power;
                end else if (connected) begin
                    off_q                 <= 8'h00;
                    mode_q <= (up_q.configured && up_q.host_port_power)
                              ? PCM_CDP : PCM_NONE;
                    port_power_enable[gi] <= up_q.host_port_power;
                end else if (!auto_cycle_mode) begin
                    // cycling off also cuts a pending off period short, so no
                    // divider level can appear once cycling is disabled
                    off_q                 <= 8'h00;
                    mode_q                <= PCM_DCP;
                    port_power_enable[gi] <= 1'b1;
                end else if (off_q != 8'h00) begin
                    off_q <= off_q - 8'h01;
                    if (off_q == 8'h01) begin
                        mode_q                <= after_q;
                        port_power_enable[gi] <= 1'b1;
                    end
                end else begin
                    port_power_enable[gi] <= 1'b1;
                    case (mode_q)
                        PCM_HIGH, PCM_MID, PCM_LOW: begin
                            if (ev) begin
                                port_power_enable[gi] <= 1'b0;
                                off_q                 <= 8'(OFF_CYC);
                                if (full_cycle && mode_q == PCM_HIGH)
                                    after_q <= PCM_MID;
                                else if (full_cycle && mode_q == PCM_MID)
                                    after_q <= PCM_LOW;
                                else
                                    after_q <= hset_en ? PCM_HSET : PCM_DCP;
                            end
                        end
                        PCM_HSET: begin
                            if (ev) begin
                                port_power_enable[gi] <= 1'b0;
                                off_q                 <= 8'(OFF_CYC);
                                after_q               <= PCM_DCP;
                            end
                        end
                        PCM_DCP: begin
                            if (ev || lv_q[gi]) begin
                                port_power_enable[gi] <= 1'b0;
                                off_q                 <= 8'(OFF_CYC);
                                after_q               <= top_div;
                            end
                        end
                        default: begin
                            mode_q <= top_div;
                        end
                    endcase
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) port_mode[gi*3 +: 3] <= 3'h0;
                else          port_mode[gi*3 +: 3] <= mode_q;
            end
        end
    endgenerate

    // per-port switching forced while any port charges
    always_ff @(posedge aclk) begin
        if (!aresetn) per_port_switching <= 1'b0;
        else per_port_switching <= (|chg_en) | !strap_q.ganged_pin;
    end

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            port_charge_enable_q <= `PCM_RST_CHG_EN;
            ctrl_q <= `PCM_RST_CTRL;
            ctrl2_q <= `PCM_RST_CTRL2;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_q && w_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                aw_q <= 1'b0;
                w_q <= 1'b0;
                if (wstrb_q[0]) begin
                    if (awaddr_q == `PCM_ADDR_CHG_EN) port_charge_enable_q <= wdata_q[3:0];
                    else if (awaddr_q == `PCM_ADDR_CTRL) ctrl_q <= wdata_q[7:0];
                    else if (awaddr_q == `PCM_ADDR_CTRL2) ctrl2_q <= wdata_q[7:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end

    // ready flags and write response code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (aw_q && w_q && !s_axi_bvalid)
                s_axi_bresp <= (awaddr_q <= `PCM_ADDR_CTRL2) ? 2'b00 : 2'b10;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                if (s_axi_araddr == `PCM_ADDR_CHG_EN) s_axi_rdata <= {28'h0, port_charge_enable_q};
                else if (s_axi_araddr == `PCM_ADDR_CTRL) s_axi_rdata <= {24'h0, ctrl_q};
                else if (s_axi_araddr == `PCM_ADDR_CTRL2) s_axi_rdata <= {24'h0, ctrl2_q};
                else if (s_axi_araddr == `PCM_ADDR_STRAPS) s_axi_rdata <= {22'h0, strap_q};
                else if (s_axi_araddr == `PCM_ADDR_STATUS)
                    s_axi_rdata <= {16'h0, port_power_enable, port_mode};
                else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // power drops on the edge that starts the off period
    AST_PWR_OFF_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        (g_port[0].off_q == 8'(OFF_CYC)) |-> !port_power_enable[0])
        else $error("port power stayed on at start of off period");
    // connection clears any off period on the next edge
    AST_CONNECT_ABANDON: assert property (@(posedge aclk) disable iff (!aresetn)
        (connected && captured_q) |=> (g_port[1].off_q == 8'h00))
        else $error("cycle kept running after connection");
    // cycling off parks enabled, unconnected ports in dedicated mode
    AST_DCP_NO_AUTO: assert property (@(posedge aclk) disable iff (!aresetn)
        (captured_q && chg_en[0] && !connected && !auto_cycle_mode && g_port[0].off_q == 8'h00)
        |=> g_port[0].mode_q == PCM_DCP)
        else $error("dedicated mode not used with cycling off");
    // downstream charging only after configuration was seen
    AST_CDP_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        (g_port[2].mode_q == PCM_CDP) |-> $past(up_q.configured))
        else $error("cdp without configuration");
    // line voltage in dedicated mode gives a full off period, then power again
    AST_DCP_TO_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
        (g_port[0].mode_q == PCM_DCP && auto_cycle_mode && !connected && chg_en[0]
         && g_port[0].off_q == 8'h00 && lv_q[0]) |=> !port_power_enable[0]
         ##(OFF_CYC) port_power_enable[0])
        else $error("dedicated exit sequence wrong");
    // a disabled port offers nothing
    AST_NOT_CHARGING: assert property (@(posedge aclk) disable iff (!aresetn)
        !chg_en[3] |=> g_port[3].mode_q == PCM_NONE)
        else $error("mode set on disabled port");
    // charging forces per-port power switching
    AST_PERPORT: assert property (@(posedge aclk) disable iff (!aresetn)
        (|chg_en) |=> per_port_switching)
        else $error("ganged switching while charging");
    // divider levels only follow enabled cycling
    AST_DIV_ONLY_AUTO: assert property (@(posedge aclk) disable iff (!aresetn)
        (g_port[0].mode_q == PCM_HIGH) |-> $past(auto_cycle_mode) || $past(auto_cycle_mode, 2))
        else $error("divider mode without cycling");
    // unconnected enabled port keeps power on unless an exit event drops it
    AST_PWR_UNCONN: assert property (@(posedge aclk) disable iff (!aresetn)
        (captured_q && chg_en[0] && !connected && g_port[0].off_q == 8'h00
         && !pu_q[0] && !lv_q[0]) |=> port_power_enable[0])
        else $error("port power off while unconnected and charging");
    // handset exit drops power and heads for dedicated mode
    AST_HSET_EXIT: assert property (@(posedge aclk) disable iff (!aresetn)
        (captured_q && chg_en[0] && !connected && auto_cycle_mode && g_port[0].off_q == 8'h00
         && g_port[0].mode_q == PCM_HSET && pu_q[0])
        |=> !port_power_enable[0] && g_port[0].after_q == PCM_DCP)
        else $error("handset exit sequence wrong");
    // full cycling steps from the high level to the mid level
    AST_FULL_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        (captured_q && chg_en[0] && !connected && auto_cycle_mode && g_port[0].off_q == 8'h00
         && g_port[0].mode_q == PCM_HIGH && full_cycle && pu_q[0])
        |=> g_port[0].after_q == PCM_MID)
        else $error("full cycle skipped a divider level");
    // main scenarios
    COV_DCP_EXIT: cover property (@(posedge aclk)
        g_port[0].mode_q == PCM_DCP && !port_power_enable[0]);
    COV_CDP: cover property (@(posedge aclk) g_port[0].mode_q == PCM_CDP);
    COV_HSET: cover property (@(posedge aclk) g_port[0].mode_q == PCM_HSET);
    COV_LOW: cover property (@(posedge aclk) g_port[0].mode_q == PCM_LOW);
endmodule // pcm_ctrl

// file: test/pcm_handset_model.sv
// portable device model that flags an unwanted charging mode on the data lines
`timescale 1ns/1ps
module pcm_handset_model (
    input  wire logic        aclk,
    input  wire logic [3:0]  port_power_enable,
    input  wire logic [11:0] port_mode,
    input  wire logic [11:0] wanted_mode,
    input  wire logic [3:0]  vdat_sel,
    input  wire logic [7:0]  reply_delay,
    output logic [3:0]       dp_pullup_detect,
    output logic [3:0]       line_voltage_detect
);
    import pcm_pkg::*;
    logic [7:0] wait_q [4];
    // after reply_delay powered cycles in an unwanted mode, signal until power drops
    always_ff @(posedge aclk) begin
        for (int p = 0; p < 4; p++) begin
            if (!port_power_enable[p] || port_mode[3*p +: 3] < PCM_HIGH ||
                port_mode[3*p +: 3] == wanted_mode[3*p +: 3]) begin
                wait_q[p]              <= 8'h00;
                dp_pullup_detect[p]    <= 1'b0;
                line_voltage_detect[p] <= 1'b0;
            end else if (wait_q[p] < reply_delay) begin
                wait_q[p] <= wait_q[p] + 8'h01;
            end else if (port_mode[3*p +: 3] == PCM_DCP && vdat_sel[p]) begin
                line_voltage_detect[p] <= 1'b1; // dedicated mode left by line voltage
            end else begin
                dp_pullup_detect[p] <= 1'b1;
            end
        end
    end
endmodule // pcm_handset_model

// file: test/test_port_charging_mode_control.sv
// self-checking bench for the charging mode controller
`timescale 1ns/1ps
`include "pcm_defines.svh"
module test_port_charging_mode_control;
    import pcm_pkg::*;
    logic          aclk, aresetn, memory_present, per_port_switching;
    pcm_straps_t   straps;
    pcm_upstream_t upstream;
    logic [3:0]    dp_pu, vdet, ppe, vdat_sel, en;
    logic [11:0]   port_mode, wanted;
    logic [7:0]    awaddr, araddr, delay;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready;
    logic [31:0]   wdata, rdata;
    logic [1:0]    bresp, rresp;
    logic [2:0]    last_mode;
    int            n_fail, n_compared, cyc, low_cnt;
    logic [2:0]    exp_mode [$];
    logic [33:0]   exp_rd [$];
    logic [1:0]    exp_wr [$];

    pcm_ctrl uut (.aclk(aclk), .aresetn(aresetn), .straps(straps), .upstream(upstream),
        .memory_present(memory_present), .dp_pullup_detect(dp_pu), .line_voltage_detect(vdet),
        .port_power_enable(ppe), .per_port_switching(per_port_switching), .port_mode(port_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    pcm_handset_model dev (.aclk(aclk), .port_power_enable(ppe), .port_mode(port_mode),
        .wanted_mode(wanted), .vdat_sel(vdat_sel), .reply_delay(delay),
        .dp_pullup_detect(dp_pu), .line_voltage_detect(vdet));

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic final_report;
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // write master: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic at, wt;
        @(posedge aclk);
        exp_wr.push_back(r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge aclk);
            at = awvalid && awready;
            wt = wvalid && wready;
            @(posedge aclk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(negedge aclk); while (!bvalid);
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    // read master; e holds {rresp, rdata}
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        exp_rd.push_back(e);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic drain;
        repeat (3000) if (exp_mode.size() > 0) @(posedge aclk);
        chk("pending modes", 0, exp_mode.size());
    endtask

    function automatic logic [33:0] stat(input logic [3:0] pw, input logic [3:0] on,
                                         input logic [2:0] m);
        logic [11:0] v;
        v = '0;
        for (int p = 0; p < 4; p++) if (on[p]) v[3*p +: 3] = m;
        return {18'h0, pw, v};
    endfunction

    // park port 0, reconfigure, re-enable and expect the mode walk s
    task automatic restart(input logic [7:0] c, input logic [7:0] c2, input logic [3:0] vs,
                           input logic [2:0] s [$]);
        exp_mode.push_back(PCM_NONE);
        wr(`PCM_ADDR_CHG_EN, {28'h0, en & 4'he}, 2'b00);
        drain();
        wr(`PCM_ADDR_CTRL, {24'h0, c}, 2'b00);
        wr(`PCM_ADDR_CTRL2, {24'h0, c2}, 2'b00);
        vdat_sel <= vs;
        foreach (s[i]) exp_mode.push_back(s[i]);
        wr(`PCM_ADDR_CHG_EN, {28'h0, en}, 2'b00);
        drain();
        wanted[2:0] <= s[$];
    endtask

    // watcher: read data, write responses, port 0 mode changes and power-off time
    always @(negedge aclk) begin
        if (rvalid && rready) chk("read", exp_rd.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            chk("bresp", {32'h0, exp_wr.pop_front()}, {32'h0, bresp});
        if (port_mode[2:0] !== last_mode) begin
            chk("mode0", exp_mode.pop_front(), port_mode[2:0]);
            if (last_mode >= PCM_HIGH && port_mode[2:0] >= PCM_HIGH)
                chk("off0", 1, ppe[0] && low_cnt >= `PCM_OFF_CYC - 1
                    && low_cnt <= `PCM_OFF_CYC + 1);
        end
        last_mode <= port_mode[2:0];
        // mode shows one cycle after power returns, so the low count is kept until then
        if (!ppe[0]) low_cnt <= low_cnt + 1;
        else if (port_mode[2:0] !== last_mode) low_cnt <= 0;
    end

    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, vdat_sel, upstream, n_fail, n_compared, cyc, low_cnt} = '0;
        straps = '0;
        straps.auto_cycle_pin_n = 1'b1;
        straps.ganged_pin = 1'b1;
        memory_present = 1'b1;
        last_mode = 3'h0;
        wanted = {PCM_DCP, PCM_DCP, PCM_DCP, PCM_NONE};
        void'($urandom(37));
        en = 4'($urandom) | 4'h1;
        delay = 8'($urandom_range(40, 5));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and unmapped accesses
        rd(`PCM_ADDR_CHG_EN, {30'h0, `PCM_RST_CHG_EN});
        rd(`PCM_ADDR_CTRL, {26'h0, `PCM_RST_CTRL});
        rd(`PCM_ADDR_CTRL2, {26'h0, `PCM_RST_CTRL2});
        rd(8'h14, {2'b10, 32'h0});
        wr(8'h14, 32'h0, 2'b10);
        rd(`PCM_ADDR_STATUS, 34'h0);
        // cycling off: enabled ports sit in dedicated mode with power on
        exp_mode.push_back(PCM_DCP);
        wr(`PCM_ADDR_CHG_EN, {28'h0, en}, 2'b00);
        drain();
        rd(`PCM_ADDR_STATUS, stat(en, en, PCM_DCP));
        chk("per_port", 1, per_port_switching);
        // 10W level, no handset, exit dedicated mode by line voltage, repeating
        restart(8'h00, 8'h02, 4'h1, '{PCM_HIGH, PCM_DCP, PCM_HIGH, PCM_DCP});
        rd(`PCM_ADDR_CTRL, 34'h0);
        // full cycle without handset
        wanted[2:0] <= PCM_NONE;
        restart(8'h00, 8'h03, 4'h0, '{PCM_HIGH, PCM_MID, PCM_LOW, PCM_DCP, PCM_HIGH});
        // 5 W level with handset, exit dedicated mode by pull-up
        wanted[2:0] <= PCM_NONE;
        restart(8'h10, 8'h00, 4'h0, '{PCM_MID, PCM_HSET, PCM_DCP, PCM_MID});
        // upstream connects and configures: cycle abandoned for charging downstream
        exp_mode.push_back(PCM_CDP);
        upstream <= 3'b111;
        drain();
        rd(`PCM_ADDR_STATUS, stat(4'hf, en, PCM_CDP));
        // second reset without configuration memory: straps decide, sampled once
        exp_mode.push_back(PCM_NONE);
        exp_mode.push_back(PCM_DCP);
        memory_present <= 1'b0;
        straps.charge_enable_straps <= 4'h3;
        upstream <= '0;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        drain();
        straps <= '0;
        repeat (50) @(posedge aclk);
        rd(`PCM_ADDR_STATUS, stat(4'h3, 4'h3, PCM_DCP));
        final_report();
    end
endmodule // test_port_charging_mode_control
